// ### bench/ptds_checker.sv
// Port-level assertions for the sensor data path.
`default_nettype none
module ptds_checker (
   input wire logic       ref_clk,
   input wire logic       rst_n,
   input wire logic [1:0] fifoMode,
   input wire logic       pressureEventFlagEnable,
   input wire logic       pressureDone,
   input wire logic       regRead,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] fifoDataByte,
   input wire logic [7:0] regRdData,
   input wire logic       regRdValid,
   input wire logic [7:0] sampleStatusFlags
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire pSet = pressureDone && pressureEventFlagEnable;
   wire rdP  = regRead && regAddr == 8'h01;
   answer_pulse_a: assert property (regRead |=> regRdValid)
      else $error("Read byte was not answered.");
   quiet_bus_a: assert property (!regRead |=> !regRdValid && regRdData == 8'h00)
      else $error("Read data without a request.");
   rsvd_status_a: assert property (!sampleStatusFlags[4] && !sampleStatusFlags[0])
      else $error("Reserved status bit set.");
   p_set_a: assert property (pSet |=> sampleStatusFlags[2])
      else $error("Pressure ready not set.");
   p_gate_a: assert property ($rose(sampleStatusFlags[2]) |-> $past(pSet))
      else $error("Pressure ready set without cause.");
   p_over_a: assert property (pSet && sampleStatusFlags[2] |=> sampleStatusFlags[6])
      else $error("Pressure overwrite not set.");
   p_clear_a: assert property (rdP && !pressureDone |=> !sampleStatusFlags[2])
      else $error("Pressure ready not cleared.");
   fifo_read_a: assert property (regRead && regAddr == 8'h0e
      |=> regRdData == $past(fifoDataByte))
      else $error("FIFO data byte misread.");
   rsvd_nibble_a: assert property (regRead && regAddr inside {8'h03, 8'h05, 8'h09}
      |=> regRdData[3:0] == 4'h0)
      else $error("Reserved nibble not zero.");
   cover property (pSet ##1 rdP);
   cover property (pSet && sampleStatusFlags[2]);
   cover property (rdP && fifoMode != 2'h0);
endmodule
bind ptds_data_status ptds_checker chk_u (.ref_clk, .rst_n, .fifoMode, .pressureEventFlagEnable,
   .pressureDone, .regRead, .regAddr, .fifoDataByte, .regRdData, .regRdValid, .sampleStatusFlags);
`default_nettype wire

// ### bench/ptds_host.sv
// Host side that fetches register bytes one at a time.
`default_nettype none
module ptds_host (
   input  wire logic       ref_clk,
   input  wire logic [7:0] regRdData,
   input  wire logic       regRdValid,
   output logic            regRead,
   output logic      [7:0] regAddr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial regRead = 1'b0;
   initial regAddr = 8'h00;
   // The answer is taken two edges after the request is raised; a released address is inverted.
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      regAddr <= ~a;
      @(posedge ref_clk);
      ok = regRdValid;
      d = regRdData;
   endtask
endmodule
`default_nettype wire

// ### bench/test_pressure_temp_data_status.sv
// Self-checking bench for the sensor data path with a behavioural model.
`default_nettype none
module test_pressure_temp_data_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, regRead, regRdValid, pressureDone, temperatureDone, ok;
   logic readyEventGeneratorEnable, pressureEventFlagEnable, temperatureEventFlagEnable;
   logic [1:0]  fifoMode;
   logic [7:0]  regAddr, regRdData, sampleStatusFlags, fifoStatusByte, fifoDataByte, got, mS;
   logic [19:0] pressureSample, mP, mD;
   logic [11:0] temperatureSample, mT;
   logic [31:0] lf = 32'h5c;
   int          n_errors = 0;
   int          samples_checked = 0;
   ptds_data_status dut_u (.ref_clk, .rst_n, .fifoMode, .readyEventGeneratorEnable,
      .pressureEventFlagEnable, .temperatureEventFlagEnable, .pressureDone, .pressureSample,
      .temperatureDone, .temperatureSample, .regRead, .regAddr, .fifoStatusByte,
      .fifoDataByte, .regRdData, .regRdValid, .sampleStatusFlags);
   ptds_host host_u (.ref_clk, .regRdData, .regRdValid, .regRead, .regAddr);
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
      samples_checked++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   function automatic logic [7:0] mRead(input logic [7:0] a);
      logic off;
      off = fifoMode == 2'h0;
      case (a)
         8'h00: return off ? mS : fifoStatusByte;
         8'h01: return off ? mP[19:12] : fifoDataByte;
         8'h02: return off ? mP[11:4] : 8'h00;
         8'h03: return off ? {mP[3:0], 4'h0} : 8'h00;
         8'h04: return off ? mT[11:4] : 8'h00;
         8'h05: return off ? {mT[3:0], 4'h0} : 8'h00;
         8'h06: return mS;
         8'h07: return mD[19:12];
         8'h08: return mD[11:4];
         8'h09: return {mD[3:0], 4'h0};
         8'h0d: return fifoStatusByte;
         8'h0e: return fifoDataByte;
         default: return 8'h00;
      endcase
   endfunction
   task automatic rdChk(input logic [7:0] a);
      logic [7:0] e;
      e = mRead(a);
      host_u.rd(a, got, ok);
      chk("valid", {19'h00000, ok}, 20'h00001);
      chk("byte", {12'h000, got}, {12'h000, e});
      if (fifoMode == 2'h0 && a == 8'h01) mS &= 8'h33;
      if (fifoMode == 2'h0 && a == 8'h04) mS &= 8'h55;
      if (fifoMode != 2'h0 && (a == 8'h01 || a == 8'h0e)) mS = 8'h00;
      chk("status", {12'h000, sampleStatusFlags}, {12'h000, mS});
   endtask
   task automatic smp(input logic isP);
      logic [19:0] v;
      lf = nx(lf);
      v = lf[19:0];
      @(posedge ref_clk);
      pressureDone <= isP;
      temperatureDone <= !isP;
      pressureSample <= v;
      temperatureSample <= v[11:0];
      @(posedge ref_clk);
      pressureDone <= 1'b0;
      temperatureDone <= 1'b0;
      if (isP && pressureEventFlagEnable) mS[6:2] = {mS[6] | mS[2], mS[5:3], 1'b1};
      if (!isP && temperatureEventFlagEnable) mS[5:1] = {mS[5] | mS[1], mS[4:2], 1'b1};
      if (readyEventGeneratorEnable) mS[7:3] = {mS[7] | mS[3], mS[6:4], 1'b1};
      if (isP) mD = v - mP;
      if (isP) mP = v;
      else mT = v[11:0];
      @(posedge ref_clk);
      chk("status", {12'h000, sampleStatusFlags}, {12'h000, mS});
   endtask
   task automatic tally_and_finish;
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      {rst_n, fifoMode, pressureDone, temperatureDone} = '0;
      {readyEventGeneratorEnable, pressureEventFlagEnable, temperatureEventFlagEnable} = '0;
      {pressureSample, temperatureSample, mP, mD, mT, mS} = '0;
      fifoStatusByte = 8'h3c;
      fifoDataByte = 8'hc3;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (int a = 0; a < 16; a++) rdChk(a[7:0]);
      for (int i = 0; i < 48; i++) begin
         lf = nx(lf);
         @(posedge ref_clk);
         fifoMode <= i[4:3];
         {readyEventGeneratorEnable, pressureEventFlagEnable} <= {lf[2], lf[3] | lf[4]};
         temperatureEventFlagEnable <= lf[5];
         {fifoDataByte, fifoStatusByte} <= lf[23:8];
         smp(lf[6]);
         if (lf[7]) smp(lf[8]);
         if (lf[9]) for (int a = 0; a < 6; a++) rdChk(a[7:0]);
         else for (int a = 6; a < 15; a++) rdChk(a[7:0]);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ### verilog/ptds_cfg.svh
// Register offsets, status bit positions and reset values for the sensor data path.
`ifndef PTDS_CFG_SVH
`define PTDS_CFG_SVH
`define PTDS_ADDR_STATUS_ALIAS 8'h00
`define PTDS_ADDR_P_HIGH       8'h01
`define PTDS_ADDR_P_MID        8'h02
`define PTDS_ADDR_P_LOW        8'h03
`define PTDS_ADDR_T_HIGH       8'h04
`define PTDS_ADDR_T_LOW        8'h05
`define PTDS_ADDR_STATUS       8'h06
`define PTDS_ADDR_PD_HIGH      8'h07
`define PTDS_ADDR_PD_MID       8'h08
`define PTDS_ADDR_PD_LOW       8'h09
`define PTDS_ADDR_FIFO_STATUS  8'h0d
`define PTDS_ADDR_FIFO_DATA    8'h0e
`define PTDS_BIT_ANY_OW        7
`define PTDS_BIT_P_OW          6
`define PTDS_BIT_T_OW          5
`define PTDS_BIT_ANY_RDY       3
`define PTDS_BIT_P_RDY         2
`define PTDS_BIT_T_RDY         1
`define PTDS_FIFO_OFF          2'h0
`define PTDS_FIFO_CIRCULAR     2'h1
`define PTDS_FIFO_FULL_STOP    2'h2
`define PTDS_RESET_BYTE        8'h00
`endif

// ### verilog/ptds_data_status.sv
// Sample status flags, pressure, temperature and pressure delta read registers.
//
// Overview of operation
// - Any-ready flag bit 3 sets on new result; FIFO off, cleared by data high-byte reads.
// - With FIFO mode non-zero, any-ready clears on FIFO data reads instead.
// - Pressure-ready bit 2 sets per pressure sample; cleared by pressure high read, or by FIFO data read with FIFO on.
// - Temperature-ready bit 1 sets per temperature sample; cleared by its high read with FIFO off, by FIFO data read otherwise.
// - Status bits 4 and 0 have no function.
// - Any-ready and any-overwrite only generated while the ready event generator is enabled.
// - Pressure ready and overwrite only generated while pressure flag enable is 1.
// - Temperature ready and overwrite only generated while temperature flag enable is 1.
// - With FIFO mode 00 the data registers show the latest samples.
// - Pressure is unsigned Q18.2 over three bytes, low nibble of last byte reserved.
// - Pressure sits at 01h, 02h, 03h, most significant first.
// - Status and results occupy 00h to 05h for a six byte burst.
// - Temperature is signed Q8.4 at 04h and upper nibble of 05h.
// - Delta registers 07h to 09h hold newest minus previous pressure.
// - Delta uses the same 20-bit Q18.2 byte layout.
// - Delta keeps updating in every FIFO mode.
// - After reset all flags and data read zero; registers are read-only.
// - FIFO mode 00 off, 01 circular, 10 full stop.
// - Address 00h aliases data status with FIFO off, FIFO status otherwise.
// - Any-overwrite bit 7 sets when unread data is replaced; clears with ready flags.
// - Pressure overwrite bit 6, temperature overwrite bit 5 set on unread replacement.
`include "ptds_cfg.svh"
`default_nettype none
module ptds_data_status (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  fifoMode,
   input  wire logic        readyEventGeneratorEnable,
   input  wire logic        pressureEventFlagEnable,
   input  wire logic        temperatureEventFlagEnable,
   input  wire logic        pressureDone,
   input  wire logic [19:0] pressureSample,
   input  wire logic        temperatureDone,
   input  wire logic [11:0] temperatureSample,
   input  wire logic        regRead,
   input  wire logic [7:0]  regAddr,
   input  wire logic [7:0]  fifoStatusByte,
   input  wire logic [7:0]  fifoDataByte,
   output logic      [7:0]  regRdData,
   output logic             regRdValid,
   output logic      [7:0]  sampleStatusFlags
);

   logic                  rstMeta;
   logic                  rstSyncN;
   ptds_pkg::ptds_state_t state_q;
   ptds_pkg::ptds_state_t state_d;

   // The release is resynchronised so every flag leaves reset on the same edge.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta  <= 1'b0;
         rstSyncN <= 1'b0;
      end else begin
         rstMeta  <= 1'b1;
         rstSyncN <= rstMeta;
      end
   end

   function automatic logic isRead(input logic rd, input logic [7:0] a, input logic [7:0] want);
      isRead = rd && (a == want);
   endfunction

   function automatic logic [7:0] statusByte(input ptds_pkg::ptds_state_t s);
      statusByte                     = 8'h00;
      statusByte[`PTDS_BIT_ANY_OW]   = s.anyOw;
      statusByte[`PTDS_BIT_P_OW]     = s.pressure_overwritten;
      statusByte[`PTDS_BIT_T_OW]     = s.temperature_overwritten;
      statusByte[`PTDS_BIT_ANY_RDY]  = s.anyRdy;
      statusByte[`PTDS_BIT_P_RDY]    = s.pRdy;
      statusByte[`PTDS_BIT_T_RDY]    = s.tRdy;
   endfunction

   logic fifoOff;
   logic clrP;
   logic clrT;
   logic clrAny;
   logic setP;
   logic setT;
   logic setAny;

   always_comb begin
      state_d = state_q;
      fifoOff = (fifoMode == `PTDS_FIFO_OFF);
      // With the FIFO on, its data port sits at 01h as well as at its own address.
      clrP    = fifoOff ? isRead(regRead, regAddr, `PTDS_ADDR_P_HIGH)
                        : (isRead(regRead, regAddr, `PTDS_ADDR_P_HIGH)
                           || isRead(regRead, regAddr, `PTDS_ADDR_FIFO_DATA));
      clrT    = fifoOff ? isRead(regRead, regAddr, `PTDS_ADDR_T_HIGH)
                        : clrP;
      clrAny  = clrP || clrT;
      setP    = pressureDone && pressureEventFlagEnable;
      setT    = temperatureDone && temperatureEventFlagEnable;
      setAny  = (pressureDone || temperatureDone) && readyEventGeneratorEnable;

      // A set in the same cycle as a clearing read wins, so no sample is missed.
      state_d.pressure_overwritten    = (setP && state_q.pRdy) || (state_q.pressure_overwritten && !clrP);
      state_d.temperature_overwritten    = (setT && state_q.tRdy) || (state_q.temperature_overwritten && !clrT);
      state_d.anyOw  = (setAny && state_q.anyRdy) || (state_q.anyOw && !clrAny);
      state_d.pRdy   = setP || (state_q.pRdy && !clrP);
      state_d.tRdy   = setT || (state_q.tRdy && !clrT);
      state_d.anyRdy = setAny || (state_q.anyRdy && !clrAny);

      if (pressureDone) begin
         state_d.pressure      = pressureSample;
         state_d.pressurePrev  = pressureSample;
         // Wraps modulo 2^20 when pressure falls; the format carries no sign.
         state_d.pressureDelta = pressureSample - state_q.pressurePrev;
      end
      if (temperatureDone) begin
         state_d.temperature = temperatureSample;
      end

      state_d.rdValid = regRead;
      state_d.rdData  = `PTDS_RESET_BYTE;
      if (regRead) begin
         case (regAddr)
            `PTDS_ADDR_STATUS_ALIAS:
               state_d.rdData = fifoOff ? statusByte(state_q) : fifoStatusByte;
            `PTDS_ADDR_P_HIGH:
               state_d.rdData = fifoOff ? state_q.pressure[19:12] : fifoDataByte;
            `PTDS_ADDR_P_MID:
               state_d.rdData = fifoOff ? state_q.pressure[11:4] : 8'h00;
            `PTDS_ADDR_P_LOW:
               state_d.rdData = fifoOff ? {state_q.pressure[3:0], 4'h0} : 8'h00;
            `PTDS_ADDR_T_HIGH:
               state_d.rdData = fifoOff ? state_q.temperature[11:4] : 8'h00;
            `PTDS_ADDR_T_LOW:
               state_d.rdData = fifoOff ? {state_q.temperature[3:0], 4'h0} : 8'h00;
            `PTDS_ADDR_STATUS:
               state_d.rdData = statusByte(state_q);
            `PTDS_ADDR_PD_HIGH:
               state_d.rdData = state_q.pressureDelta[19:12];
            `PTDS_ADDR_PD_MID:
               state_d.rdData = state_q.pressureDelta[11:4];
            `PTDS_ADDR_PD_LOW:
               state_d.rdData = {state_q.pressureDelta[3:0], 4'h0};
            `PTDS_ADDR_FIFO_STATUS:
               state_d.rdData = fifoStatusByte;
            `PTDS_ADDR_FIFO_DATA:
               state_d.rdData = fifoDataByte;
            default:
               state_d.rdData = 8'h00;
         endcase
      end
      state_d.status = statusByte(state_d);
   end

   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign regRdData         = state_q.rdData;
   assign regRdValid        = state_q.rdValid;
   assign sampleStatusFlags = state_q.status;

endmodule
`default_nettype wire

// ### verilog/ptds_pkg.sv
// Types shared by the sensor data path.
`default_nettype none
package ptds_pkg;
   typedef enum logic [1:0] {
      PTDS_FIFO_OFF_E       = 2'b00,
      PTDS_FIFO_CIRCULAR_E  = 2'b01,
      PTDS_FIFO_FULL_STOP_E = 2'b10,
      PTDS_FIFO_SPARE_E     = 2'b11
   } ptds_fifo_mode_t;

   typedef struct packed {
      logic        anyOw;
      logic        pressure_overwritten;
      logic        temperature_overwritten;
      logic        anyRdy;
      logic        pRdy;
      logic        tRdy;
      logic [19:0] pressure;
      logic [11:0] temperature;
      logic [19:0] pressurePrev;
      logic [19:0] pressureDelta;
      logic [7:0]  rdData;
      logic        rdValid;
      logic [7:0]  status;
   } ptds_state_t;
endpackage
`default_nettype wire
